// ### hdl/iplb_consts.svh
// offsets, field layouts, reset values and level codes of the priority level bank
`ifndef IPLB_CONSTS_SVH
`define IPLB_CONSTS_SVH

// register byte addresses (one aligned word each)
`define IPLB_OFS_CTL_8 12'h000
`define IPLB_OFS_CTL_9 12'h004
`define IPLB_OFS_CTL_10 12'h008
`define IPLB_OFS_CTL_11 12'h00C
`define IPLB_OFS_CTL_12 12'h010
`define IPLB_OFS_CTL_13 12'h014
`define IPLB_OFS_CTL_15 12'h018
`define IPLB_OFS_STATUS 12'h01C

// implemented-bit masks per register
`define IPLB_MASK_CTL_8 16'h0077
`define IPLB_MASK_CTL_9 16'h7770
`define IPLB_MASK_CTL_10 16'h7777
`define IPLB_MASK_CTL_11 16'h0077
`define IPLB_MASK_CTL_12 16'h0770
`define IPLB_MASK_CTL_13 16'h0770
`define IPLB_MASK_CTL_15 16'h0700

// every field resets to level 4
`define IPLB_LEVEL_RESET 3'h4
`define IPLB_LEVEL_OFF 3'h0
`define IPLB_LEVEL_LOW 3'h1
`define IPLB_LEVEL_TOP 3'h7

// field low-bit positions
`define IPLB_POS_HI 12
`define IPLB_POS_MID 8
`define IPLB_POS_LO4 4
`define IPLB_POS_LO0 0

`define IPLB_NUM_SRC 16

`endif

// ### hdl/iplb_pkg.sv
// types shared by the priority level bank
`default_nettype none
package iplb_pkg;
   typedef logic [2:0] iplb_level_type;
   typedef enum logic [2:0] {
      IPLB_ST_IDLE = 3'b001,
      IPLB_ST_WRITE = 3'b010,
      IPLB_ST_READ = 3'b100
   } iplb_state_type;
endpackage
`default_nettype wire

// ### hdl/iplb_level_field.sv
// one 3-bit priority field with its decoded level and enable
`include "iplb_consts.svh"
`default_nettype none
module iplb_level_field
   import iplb_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic wr_en,
   input wire logic [2:0] wr_val,
   output iplb_level_type level,
   output logic enabled
);
   iplb_level_type field_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         field_q <= `IPLB_LEVEL_RESET;
      end else if (wr_en) begin
         field_q <= wr_val;
      end
   end

   // binary code is the level itself: 001 lowest, 111 highest
   assign level = field_q;
   assign enabled = (field_q != `IPLB_LEVEL_OFF);
endmodule
`default_nettype wire

// ### hdl/iplb_bank.sv
// priority level bank: AHB-Lite slave holding sixteen 3-bit source levels
//
// Notes on behaviour
// - code 111 is level 7, highest
// - code 000 disables the source
// - code 001 is level 1, lowest enabled
// - unused bits read zero, ignore writes
// - fields reset to 100, fully read/write
// - reg 8: spi2 event 6:4, fault 2:0
// - reg 9: capture 5,4,3 at 14:12,10:8,6:4
// - reg 10: compare 7,6,5, capture 6
// - reg 11: parallel port 6:4, compare8 2:0
// - reg 12: twowire2 master 10:8, slave 6:4
// - reg 13: ext irq4 10:8, irq3 6:4
// - reg 15: calendar clock 10:8 only
`include "iplb_consts.svh"
`default_nettype none
module iplb_bank
   import iplb_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic [47:0] src_levels,
   output logic [15:0] src_enabled
);
   // ----------------------------------------------------------------
   // source order: index i owns bits 3i+2..3i of src_levels
   // ----------------------------------------------------------------
   // 0 serial_periph2_event 1 serial_periph2_fault 2 capture5 3 capture4
   // 4 capture3 5 compare7 6 compare6 7 compare5 8 capture6
   // 9 parallel_port 10 compare8 11 twowire2_master 12 twowire2_slave
   // 13 ext_irq4 14 ext_irq3 15 calendar_clock

   // ----------------------------------------------------------------
   // address phase capture
   // ----------------------------------------------------------------
   iplb_state_type state_q;
   iplb_state_type state_d;
   logic [11:0] addr_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [47:0] levels_q;
   logic [15:0] enabled_q;

   wire logic take_req = hsel && hready && htrans[1];
   wire logic in_write = (state_q == IPLB_ST_WRITE);

   always_comb begin
      state_d = IPLB_ST_IDLE;
      if (take_req) begin
         state_d = hwrite ? IPLB_ST_WRITE : IPLB_ST_READ;
      end
      case (state_q)
         IPLB_ST_IDLE, IPLB_ST_WRITE, IPLB_ST_READ: begin
         end
         default: begin
            state_d = IPLB_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= IPLB_ST_IDLE;
         addr_q <= 12'h000;
      end else begin
         state_q <= state_d;
         if (take_req) begin
            addr_q <= haddr[11:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   wire logic wr_8 = in_write && (addr_q == `IPLB_OFS_CTL_8);
   wire logic wr_9 = in_write && (addr_q == `IPLB_OFS_CTL_9);
   wire logic wr_10 = in_write && (addr_q == `IPLB_OFS_CTL_10);
   wire logic wr_11 = in_write && (addr_q == `IPLB_OFS_CTL_11);
   wire logic wr_12 = in_write && (addr_q == `IPLB_OFS_CTL_12);
   wire logic wr_13 = in_write && (addr_q == `IPLB_OFS_CTL_13);
   wire logic wr_15 = in_write && (addr_q == `IPLB_OFS_CTL_15);

   // per-source write strobe and source bit position in hwdata
   logic [15:0] src_wr;
   logic [4:0] src_pos [16];

   assign src_wr = {wr_15, wr_13, wr_13, wr_12, wr_12, wr_11, wr_11, wr_10,
                    wr_10, wr_10, wr_10, wr_9, wr_9, wr_9, wr_8, wr_8};
   assign src_pos[0] = 5'(`IPLB_POS_LO4);
   assign src_pos[1] = 5'(`IPLB_POS_LO0);
   assign src_pos[2] = 5'(`IPLB_POS_HI);
   assign src_pos[3] = 5'(`IPLB_POS_MID);
   assign src_pos[4] = 5'(`IPLB_POS_LO4);
   assign src_pos[5] = 5'(`IPLB_POS_HI);
   assign src_pos[6] = 5'(`IPLB_POS_MID);
   assign src_pos[7] = 5'(`IPLB_POS_LO4);
   assign src_pos[8] = 5'(`IPLB_POS_LO0);
   assign src_pos[9] = 5'(`IPLB_POS_LO4);
   assign src_pos[10] = 5'(`IPLB_POS_LO0);
   assign src_pos[11] = 5'(`IPLB_POS_MID);
   assign src_pos[12] = 5'(`IPLB_POS_LO4);
   assign src_pos[13] = 5'(`IPLB_POS_MID);
   assign src_pos[14] = 5'(`IPLB_POS_LO4);
   assign src_pos[15] = 5'(`IPLB_POS_MID);

   // ----------------------------------------------------------------
   // priority fields
   // ----------------------------------------------------------------
   logic [47:0] lvl_w;
   logic [15:0] en_w;

   genvar gi;
   generate
      for (gi = 0; gi < `IPLB_NUM_SRC; gi = gi + 1) begin : g_src
         iplb_level_field u_field (
            .hclk(hclk),
            .hresetn(hresetn),
            .wr_en(src_wr[gi]),
            .wr_val(hwdata[src_pos[gi] +: 3]),
            .level(lvl_w[3*gi +: 3]),
            .enabled(en_w[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // register images, unused bits held at zero
   // ----------------------------------------------------------------
   wire logic [15:0] img_8 = {9'h000, lvl_w[2:0], 1'b0, lvl_w[5:3]};
   wire logic [15:0] img_9 = {1'b0, lvl_w[8:6], 1'b0, lvl_w[11:9], 1'b0, lvl_w[14:12], 4'h0};
   wire logic [15:0] img_10 = {1'b0, lvl_w[17:15], 1'b0, lvl_w[20:18], 1'b0, lvl_w[23:21],
                               1'b0, lvl_w[26:24]};
   wire logic [15:0] img_11 = {9'h000, lvl_w[29:27], 1'b0, lvl_w[32:30]};
   wire logic [15:0] img_12 = {5'h00, lvl_w[35:33], 1'b0, lvl_w[38:36], 4'h0};
   wire logic [15:0] img_13 = {5'h00, lvl_w[41:39], 1'b0, lvl_w[44:42], 4'h0};
   wire logic [15:0] img_15 = {5'h00, lvl_w[47:45], 8'h00};

   // read mux on the address phase so data stands in the next cycle
   wire logic [11:0] ra = haddr[11:0];

   always_comb begin
      rdata_d = 32'h0000_0000;
      case (ra)
         `IPLB_OFS_CTL_8: begin
            rdata_d = {16'h0000, img_8 & `IPLB_MASK_CTL_8};
         end
         `IPLB_OFS_CTL_9: begin
            rdata_d = {16'h0000, img_9 & `IPLB_MASK_CTL_9};
         end
         `IPLB_OFS_CTL_10: begin
            rdata_d = {16'h0000, img_10 & `IPLB_MASK_CTL_10};
         end
         `IPLB_OFS_CTL_11: begin
            rdata_d = {16'h0000, img_11 & `IPLB_MASK_CTL_11};
         end
         `IPLB_OFS_CTL_12: begin
            rdata_d = {16'h0000, img_12 & `IPLB_MASK_CTL_12};
         end
         `IPLB_OFS_CTL_13: begin
            rdata_d = {16'h0000, img_13 & `IPLB_MASK_CTL_13};
         end
         `IPLB_OFS_CTL_15: begin
            rdata_d = {16'h0000, img_15 & `IPLB_MASK_CTL_15};
         end
         `IPLB_OFS_STATUS: begin
            rdata_d = {16'h0000, en_w};
         end
         default: begin
            rdata_d = 32'h0000_0000;
         end
      endcase
      if (!(take_req && !hwrite)) begin
         rdata_d = 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= 32'h0000_0000;
         levels_q <= {16{`IPLB_LEVEL_RESET}};
         enabled_q <= 16'hFFFF;
      end else begin
         rdata_q <= rdata_d;
         levels_q <= lvl_w;
         enabled_q <= en_w;
      end
   end

   // zero-wait slave, always OKAY
   assign hrdata = rdata_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign src_levels = levels_q;
   assign src_enabled = enabled_q;
endmodule
`default_nettype wire

// ### sim/iplb_bank_assertions.sv
// port assertions for the priority level bank
`include "iplb_consts.svh"
`default_nettype none
module iplb_bank_assertions
   import iplb_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [47:0] src_levels,
   input wire logic [15:0] src_enabled
);
   logic rd_q;
   logic [11:0] ad_q;
   logic [15:0] en_c;
   logic [15:0] msk_c;
   wire wr = hsel & hready & htrans[1] & hwrite;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_q <= 1'b0;
         ad_q <= 12'h000;
      end else begin
         rd_q <= hsel & hready & htrans[1] & ~hwrite;
         ad_q <= haddr[11:0];
      end
   end
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         en_c[i] = |src_levels[3*i +: 3];
      end
   end
   assign msk_c = ad_q == `IPLB_OFS_CTL_8 ? `IPLB_MASK_CTL_8 :
      ad_q == `IPLB_OFS_CTL_9 ? `IPLB_MASK_CTL_9 :
      ad_q == `IPLB_OFS_CTL_10 ? `IPLB_MASK_CTL_10 :
      ad_q == `IPLB_OFS_CTL_11 ? `IPLB_MASK_CTL_11 :
      ad_q == `IPLB_OFS_CTL_12 ? `IPLB_MASK_CTL_12 :
      ad_q == `IPLB_OFS_CTL_13 ? `IPLB_MASK_CTL_13 :
      ad_q == `IPLB_OFS_CTL_15 ? `IPLB_MASK_CTL_15 :
      ad_q == `IPLB_OFS_STATUS ? 16'hFFFF : 16'h0000;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_BUS: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   AST_IDLE: assert property (!rd_q |-> hrdata == 32'h0)
      else $error("read data not zero outside a read");
   AST_UNUSED: assert property (rd_q |-> (hrdata & ~{16'h0, msk_c}) == 32'h0)
      else $error("unused bit reads one");
   AST_ENABLE: assert property (src_enabled == en_c)
      else $error("enable differs from level");
   AST_RESET: assert property ($rose(hresetn) |-> src_levels == {16{3'h4}})
      else $error("levels not four after reset");
   // field loads at the end of the data phase, the level port one edge later
   AST_WR8: assert property (wr && haddr[11:0] == `IPLB_OFS_CTL_8 |-> ##3
      src_levels[5:0] == {$past(hwdata[2:0], 2), $past(hwdata[6:4], 2)}) else $error("ctl8 write lost");
   AST_WR9: assert property (wr && haddr[11:0] == `IPLB_OFS_CTL_9 |-> ##3
      src_levels[8:6] == $past(hwdata[14:12], 2)) else $error("ctl9 write lost");
   AST_WR15: assert property (wr && haddr[11:0] == `IPLB_OFS_CTL_15 |-> ##3
      src_levels[47:45] == $past(hwdata[10:8], 2)) else $error("ctl15 write lost");
endmodule
bind iplb_bank iplb_bank_assertions iplb_bank_assertions_inst (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .src_levels, .src_enabled);
`default_nettype wire

// ### sim/iplb_bank_test.sv
// self-checking bench for the priority level bank
`include "iplb_consts.svh"
`default_nettype none
module iplb_bank_test
   import iplb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk, hsel = 0, hwrite = 0, hresetn = 0;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 0, hwdata = 0, hrdata;
   logic hreadyout, hresp;
   logic [47:0] src_levels;
   logic [15:0] src_enabled;
   int failures = 0;
   int comparisons = 0;
   logic [15:0] msk [7] = '{`IPLB_MASK_CTL_8, `IPLB_MASK_CTL_9, `IPLB_MASK_CTL_10,
      `IPLB_MASK_CTL_11, `IPLB_MASK_CTL_12, `IPLB_MASK_CTL_13, `IPLB_MASK_CTL_15};
   // register and low bit of each source field
   int rg [16] = '{0, 0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 4, 4, 5, 5, 6};
   int ps [16] = '{4, 0, 12, 8, 4, 12, 8, 4, 0, 4, 0, 8, 4, 8, 4, 8};
   iplb_bank iplb_bank_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .src_levels, .src_enabled);
   task automatic finish_test;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            failures++;
            finish_test;
         end
         @(posedge hclk);
      end
   endtask
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {20'h0, a};
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy;
      rd = hrdata;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      xfer(1'b0, a, 32'h0, d);
      check({16'h0, d}, {16'h0, exp});
   endtask
   task automatic t_reset;
      for (int k = 0; k < 7; k++) begin
         rd_chk(12'(4 * k), {16'h0, msk[k] & 16'h4444});
      end
      rd_chk(`IPLB_OFS_STATUS, 32'h0000_FFFF);
      rd_chk(12'h020, 32'h0);
      check(src_levels, {16{3'h4}});
   endtask
   task automatic t_codes;
      logic [15:0] d [7];
      logic [47:0] el;
      logic [15:0] ee;
      logic [31:0] r;
      for (int p = 0; p < 8; p++) begin
         for (int k = 0; k < 7; k++) begin
            d[k] = 16'(p * 16'h1111) ^ 16'(k * 16'h0123);
            xfer(1'b1, 12'(4 * k), {16'hFFFF, ~msk[k] | d[k]}, r);
         end
         for (int k = 0; k < 7; k++) begin
            rd_chk(12'(4 * k), {16'h0, d[k] & msk[k]});
         end
         for (int i = 0; i < 16; i++) begin
            el[3*i +: 3] = d[rg[i]][ps[i] +: 3];
            ee[i] = |el[3*i +: 3];
         end
         check(src_levels, el);
         check({32'h0, src_enabled}, {32'h0, ee});
      end
   endtask
   task automatic t_rereset;
      hresetn <= 1'b0;
      repeat (5) @(posedge hclk);
      check(src_levels, {16{3'h4}});
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk(`IPLB_OFS_CTL_10, 32'h0000_4444);
   endtask
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset;
      t_codes;
      t_rereset;
      finish_test;
   end
endmodule
`default_nettype wire
